// *** rtl/mis_exec.v ***
/*
  Execution datapath of the 8-bit core for the add, and, call,
  clear, watchdog, complement, decimal adjust, decrement and
  power-down operations, with flags, watchdog and call stack.
  Assumes the decoder supplies the addressed data byte on op_mem
  in the cycle of op_valid and holds the write address for the
  following cycle, when mem_we_r is seen.
*/
`include "mis_exec_map.vh"
`default_nettype none

module mis_exec #(
  parameter PC_W = `MIS_PC_W,
  parameter STACK_DEPTH = `MIS_STACK_DEPTH,
  parameter SP_W = `MIS_SP_W,
  parameter WDT_PRE_W = `MIS_WDT_PRE_W,
  parameter WDT_CNT_W = `MIS_WDT_CNT_W
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // operation from the decoder
  input wire op_valid,
  input wire [`MIS_OP_W-1:0] op_code,
  input wire [7:0] op_mem,
  input wire [7:0] op_imm,
  input wire [2:0] op_bit,
  input wire [PC_W-1:0] op_target,
  output wire op_accept,
  // wake from power-down
  input wire wake_req,
  // data memory write
  output reg mem_we_r,
  output reg [7:0] mem_wdata_r,
  // working register and status flags
  output reg [7:0] working_register_r,
  output reg carry_r,
  output reg half_carry_flag_r,
  output reg zero_r,
  output reg twos_complement_range_flag_r,
  output reg timeout_flag_r,
  output reg sleep_flag_r,
  // program counter and stack
  output reg [PC_W-1:0] pc_r,
  output reg stack_push_r,
  output reg [PC_W-1:0] stack_data_r,
  output reg [SP_W-1:0] stack_level_r,
  // power and watchdog state
  output wire sys_clk_en,
  output reg halted_r,
  output reg [WDT_CNT_W-1:0] watchdog_counter_r,
  output reg wdt_expire_r
);

  localparam integer SP_LAST_I = STACK_DEPTH - 1;
  localparam [SP_W-1:0] SP_LAST = SP_LAST_I[SP_W-1:0];
  localparam [SP_W-1:0] SP_ONE = 1;
  localparam [PC_W-1:0] PC_ONE = 1;
  reg [WDT_PRE_W-1:0] wdt_pre_r;
  reg pre_first_seen_r;
  reg pre_second_seen_r;
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  reg [SP_W-1:0] sp_r;
  // next-state values
  reg [7:0] w_nxt;
  reg c_nxt;
  reg ac_nxt;
  reg z_nxt;
  reg ov_nxt;
  reg we_nxt;
  reg [7:0] wd_nxt;
  reg wdt_clr;
  reg pre1_nxt;
  reg pre2_nxt;
  reg halt_go;
  reg push_go;
  // adder operands and results
  reg [7:0] add_b;
  reg add_cin;
  wire [4:0] add_lo;
  wire [4:0] add_hi;
  wire [7:0] add_sum;
  wire add_ov;
  // bcd adjust terms
  wire [4:0] bcd_lo_raw;
  wire bcd_lo_fix;
  wire [4:0] bcd_lo;
  wire [4:0] bcd_hi_raw;
  wire bcd_hi_fix;
  wire [4:0] bcd_hi;
  wire [7:0] bcd_byte;
  wire [7:0] dec_byte;
  wire [7:0] and_m;
  wire [7:0] and_i;
  wire [7:0] bit_mask;
  wire go;
  wire pre_tick;
  wire wdt_timeout;
  // no op is taken while the clock is gated
  assign op_accept = op_valid & ~halted_r;
  assign go = op_accept;
  assign sys_clk_en = ~halted_r;
  // shared adder, split at the nibble for half carry
  assign add_lo = {1'b0, working_register_r[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  assign add_hi = {1'b0, working_register_r[7:4]} + {1'b0, add_b[7:4]} + {4'h0, add_lo[4]};
  assign add_sum = {add_hi[3:0], add_lo[3:0]};
  assign add_ov = (working_register_r[7] == add_b[7]) && (add_sum[7] != working_register_r[7]);
  // decimal adjust: low nibble carry feeds the high nibble
  assign bcd_lo_raw = {1'b0, working_register_r[3:0]};
  assign bcd_lo_fix = (bcd_lo_raw > `MIS_BCD_LIMIT) | half_carry_flag_r;
  assign bcd_lo = bcd_lo_fix ? bcd_lo_raw + `MIS_BCD_FIX : bcd_lo_raw;
  assign bcd_hi_raw = {1'b0, working_register_r[7:4]} + {4'h0, bcd_lo[4]};
  assign bcd_hi_fix = (bcd_hi_raw > `MIS_BCD_LIMIT) | carry_r;
  assign bcd_hi = bcd_hi_fix ? bcd_hi_raw + `MIS_BCD_FIX : bcd_hi_raw;
  assign bcd_byte = {bcd_hi[3:0], bcd_lo[3:0]};
  assign dec_byte = op_mem - `MIS_BYTE_ONE;
  assign and_m = working_register_r & op_mem;
  assign and_i = working_register_r & op_imm;
  assign bit_mask = ~(`MIS_BYTE_ONE << op_bit);
  // prescaler wraps every 2^WDT_PRE_W clocks
  assign pre_tick = &wdt_pre_r;
  assign wdt_timeout = pre_tick & (&watchdog_counter_r);
  always @* begin
    add_b = op_mem;
    add_cin = 1'b0;
    case (op_code)
      `MIS_OP_ADC_W: add_cin = carry_r;
      `MIS_OP_ADC_M: add_cin = carry_r;
      `MIS_OP_ADD_I: add_b = op_imm;
      default: add_cin = 1'b0;
    endcase
  end
  // every flag defaults to its held value
  always @* begin
    w_nxt = working_register_r;
    c_nxt = carry_r;
    ac_nxt = half_carry_flag_r;
    z_nxt = zero_r;
    ov_nxt = twos_complement_range_flag_r;
    we_nxt = 1'b0;
    wd_nxt = mem_wdata_r;
    wdt_clr = 1'b0;
    pre1_nxt = pre_first_seen_r;
    pre2_nxt = pre_second_seen_r;
    halt_go = 1'b0;
    push_go = 1'b0;
    if (go) begin
      case (op_code)
        `MIS_OP_ADC_W, `MIS_OP_ADD_W, `MIS_OP_ADD_I, `MIS_OP_ADC_M, `MIS_OP_ADD_M: begin
          if ((op_code == `MIS_OP_ADC_M) || (op_code == `MIS_OP_ADD_M)) begin
            we_nxt = 1'b1;
            wd_nxt = add_sum;
          end else begin
            w_nxt = add_sum;
          end
          c_nxt = add_hi[4];
          ac_nxt = add_lo[4];
          z_nxt = (add_sum == `MIS_BYTE_ZERO);
          ov_nxt = add_ov;
        end
        `MIS_OP_AND_W: begin
          w_nxt = and_m;
          z_nxt = (and_m == `MIS_BYTE_ZERO);
        end
        `MIS_OP_AND_I: begin
          w_nxt = and_i;
          z_nxt = (and_i == `MIS_BYTE_ZERO);
        end
        `MIS_OP_AND_M: begin
          we_nxt = 1'b1;
          wd_nxt = and_m;
          z_nxt = (and_m == `MIS_BYTE_ZERO);
        end
        `MIS_OP_CALL: begin
          push_go = 1'b1;
        end
        `MIS_OP_ZERO_M: begin
          we_nxt = 1'b1;
          wd_nxt = `MIS_BYTE_ZERO;
        end
        `MIS_OP_BITCLR: begin
          we_nxt = 1'b1;
          wd_nxt = op_mem & bit_mask;
        end
        `MIS_OP_KICK: begin
          wdt_clr = 1'b1;
          pre1_nxt = 1'b0;
          pre2_nxt = 1'b0;
        end
        `MIS_OP_PRE1, `MIS_OP_PRE2: begin
          // a repeat of the same preclear is not its own partner
          if ((op_code == `MIS_OP_PRE1) ? pre_second_seen_r : pre_first_seen_r) begin
            wdt_clr = 1'b1;
            pre1_nxt = 1'b0;
            pre2_nxt = 1'b0;
          end else if (op_code == `MIS_OP_PRE1) begin
            pre1_nxt = 1'b1;
          end else begin
            pre2_nxt = 1'b1;
          end
        end
        `MIS_OP_INV_M: begin
          we_nxt = 1'b1;
          wd_nxt = ~op_mem;
          z_nxt = (~op_mem == `MIS_BYTE_ZERO);
        end
        `MIS_OP_INV_W: begin
          w_nxt = ~op_mem;
          z_nxt = (~op_mem == `MIS_BYTE_ZERO);
        end
        `MIS_OP_BCD: begin
          we_nxt = 1'b1;
          wd_nxt = bcd_byte;
          c_nxt = bcd_hi_fix ? 1'b1 : carry_r;
        end
        `MIS_OP_DEC_M: begin
          we_nxt = 1'b1;
          wd_nxt = dec_byte;
          z_nxt = (dec_byte == `MIS_BYTE_ZERO);
        end
        `MIS_OP_DEC_W: begin
          w_nxt = dec_byte;
          z_nxt = (dec_byte == `MIS_BYTE_ZERO);
        end
        `MIS_OP_HALT: begin
          halt_go = 1'b1;
          wdt_clr = 1'b1;
        end
        default: w_nxt = working_register_r;
      endcase
    end
  end

  // datapath registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      working_register_r <= `MIS_W_RST;
      carry_r <= `MIS_FLAG_RST;
      half_carry_flag_r <= `MIS_FLAG_RST;
      zero_r <= `MIS_FLAG_RST;
      twos_complement_range_flag_r <= `MIS_FLAG_RST;
      mem_we_r <= 1'b0;
      mem_wdata_r <= `MIS_BYTE_ZERO;
      pre_first_seen_r <= 1'b0;
      pre_second_seen_r <= 1'b0;
    end else begin
      working_register_r <= w_nxt;
      carry_r <= c_nxt;
      half_carry_flag_r <= ac_nxt;
      zero_r <= z_nxt;
      twos_complement_range_flag_r <= ov_nxt;
      mem_we_r <= we_nxt;
      mem_wdata_r <= wd_nxt;
      pre_first_seen_r <= pre1_nxt;
      pre_second_seen_r <= pre2_nxt;
    end
  end

  // program counter and push bookkeeping
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= {PC_W{1'b0}};
      stack_push_r <= 1'b0;
      stack_data_r <= {PC_W{1'b0}};
      sp_r <= {SP_W{1'b0}};
      stack_level_r <= {SP_W{1'b0}};
    end else begin
      stack_push_r <= push_go;
      if (push_go) begin
        stack_data_r <= pc_r + PC_ONE;
        pc_r <= op_target;
        // a full stack wraps and overwrites the oldest entry
        sp_r <= (sp_r == SP_LAST) ? {SP_W{1'b0}} : sp_r + SP_ONE;
        if (stack_level_r != SP_LAST + SP_ONE) begin
          stack_level_r <= stack_level_r + SP_ONE;
        end
      end else if (go) begin
        pc_r <= pc_r + PC_ONE;
      end
    end
  end

  // stack storage needs no reset
  always @(posedge clk) begin
    if (push_go) begin
      stack_mem[sp_r] <= pc_r + PC_ONE;
    end
  end

  // watchdog runs on while halted so a timeout can wake the core
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdt_pre_r <= {WDT_PRE_W{1'b0}};
      watchdog_counter_r <= {WDT_CNT_W{1'b0}};
      wdt_expire_r <= 1'b0;
    end else begin
      wdt_expire_r <= wdt_timeout & ~wdt_clr;
      if (wdt_clr) begin
        wdt_pre_r <= {WDT_PRE_W{1'b0}};
        watchdog_counter_r <= {WDT_CNT_W{1'b0}};
      end else begin
        wdt_pre_r <= wdt_pre_r + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
        if (pre_tick) begin
          watchdog_counter_r <= watchdog_counter_r + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // timeout and sleep flags; a timeout set wins over a clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout_flag_r <= 1'b0;
      sleep_flag_r <= 1'b0;
    end else begin
      if (wdt_timeout) begin
        timeout_flag_r <= 1'b1;
      end else if (wdt_clr) begin
        timeout_flag_r <= 1'b0;
      end
      if (halt_go) begin
        sleep_flag_r <= 1'b1;
      end else if (wdt_clr) begin
        sleep_flag_r <= 1'b0;
      end
    end
  end

  // power-down state; contents are held since nothing is accepted
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      halted_r <= 1'b0;
    end else if (halt_go) begin
      halted_r <= 1'b1;
    end else if (halted_r && (wake_req || wdt_timeout)) begin
      halted_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** rtl/mis_exec_map.vh ***
/*
  Constants for the instruction execution block: operation codes
  from the decoder, arithmetic constants and default sizes.
  Assumes the decoder presents one operation code per cycle.
*/
`ifndef MIS_EXEC_MAP_VH
`define MIS_EXEC_MAP_VH

// operation codes, 5 bits wide
`define MIS_OP_W 5
`define MIS_OP_NOP 5'h00
`define MIS_OP_ADC_W 5'h01
`define MIS_OP_ADC_M 5'h02
`define MIS_OP_ADD_W 5'h03
`define MIS_OP_ADD_I 5'h04
`define MIS_OP_ADD_M 5'h05
`define MIS_OP_AND_W 5'h06
`define MIS_OP_AND_I 5'h07
`define MIS_OP_AND_M 5'h08
`define MIS_OP_CALL 5'h09
`define MIS_OP_ZERO_M 5'h0A
`define MIS_OP_BITCLR 5'h0B
`define MIS_OP_KICK 5'h0C
`define MIS_OP_PRE1 5'h0D
`define MIS_OP_PRE2 5'h0E
`define MIS_OP_INV_M 5'h0F
`define MIS_OP_INV_W 5'h10
`define MIS_OP_BCD 5'h11
`define MIS_OP_DEC_M 5'h12
`define MIS_OP_DEC_W 5'h13
`define MIS_OP_HALT 5'h14

// arithmetic constants
`define MIS_BYTE_ZERO 8'h00
`define MIS_BYTE_ONE 8'h01
`define MIS_BCD_LIMIT 5'h09
`define MIS_BCD_FIX 5'h06

// reset values
`define MIS_W_RST 8'h00
`define MIS_FLAG_RST 1'h0

// default sizes
`define MIS_PC_W 11
`define MIS_STACK_DEPTH 6
`define MIS_SP_W 3
`define MIS_WDT_PRE_W 8
`define MIS_WDT_CNT_W 8

`endif

// *** tb/mis_exec_asserts.sv ***
/*
  Checker for the execution block: operation results, call, clear,
  watchdog and power-down relations at the top ports.
  Assumes it is bound into mis_exec and sees its ports by name.
*/
`include "mis_exec_map.vh"
`default_nettype none
module mis_exec_asserts #(
  parameter PC_W = 11,
  parameter WDT_CNT_W = 8
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // operation
  input wire [4:0] op_code,
  input wire [7:0] op_mem,
  input wire [7:0] op_imm,
  input wire [2:0] op_bit,
  input wire [PC_W-1:0] op_target,
  input wire op_accept,
  // results
  input wire mem_we_r,
  input wire [7:0] mem_wdata_r,
  input wire [7:0] working_register_r,
  input wire carry_r,
  input wire half_carry_flag_r,
  input wire zero_r,
  input wire twos_complement_range_flag_r,
  input wire timeout_flag_r,
  input wire sleep_flag_r,
  input wire [PC_W-1:0] pc_r,
  input wire stack_push_r,
  input wire [PC_W-1:0] stack_data_r,
  input wire halted_r,
  input wire sys_clk_en,
  input wire [WDT_CNT_W-1:0] watchdog_counter_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_adc_w;
    op_accept && op_code == `MIS_OP_ADC_W |=> working_register_r == $past(working_register_r) + $past(op_mem) + $past(carry_r);
  endproperty
  a_adc_w: assert property (p_adc_w) else $error("adc to w result wrong");
  property p_add_m;
    op_accept && op_code == `MIS_OP_ADD_M |=> mem_we_r && mem_wdata_r == $past(working_register_r) + $past(op_mem);
  endproperty
  a_add_m: assert property (p_add_m) else $error("add to memory wrong");
  property p_and_i;
    op_accept && op_code == `MIS_OP_AND_I |=> working_register_r == ($past(working_register_r) & $past(op_imm))
      && $stable(carry_r) && $stable(half_carry_flag_r) && $stable(twos_complement_range_flag_r);
  endproperty
  a_and_i: assert property (p_and_i) else $error("and immediate wrong");
  property p_dec_w;
    op_accept && op_code == `MIS_OP_DEC_W |=> working_register_r == $past(op_mem) - 8'h01 && !mem_we_r
      && zero_r == (working_register_r == 8'h00);
  endproperty
  a_dec_w: assert property (p_dec_w) else $error("decrement to w wrong");
  property p_zero;
    op_accept && op_code == `MIS_OP_ZERO_M |=> mem_we_r && mem_wdata_r == 8'h00 && $stable(zero_r) && $stable(carry_r);
  endproperty
  a_zero: assert property (p_zero) else $error("byte clear wrong");
  property p_bitclr;
    op_accept && op_code == `MIS_OP_BITCLR |=> mem_wdata_r == ($past(op_mem) & ~(8'h01 << $past(op_bit)));
  endproperty
  a_bitclr: assert property (p_bitclr) else $error("bit clear wrong");
  property p_call;
    op_accept && op_code == `MIS_OP_CALL |=> pc_r == $past(op_target) && stack_push_r
      && stack_data_r == $past(pc_r) + 1'b1 && $stable(carry_r) && $stable(zero_r);
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_kick;
    op_accept && op_code == `MIS_OP_KICK |=> watchdog_counter_r == 0 && !sleep_flag_r && !timeout_flag_r;
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog kick wrong");
  property p_halt;
    op_accept && op_code == `MIS_OP_HALT |=> halted_r && !sys_clk_en && sleep_flag_r && !timeout_flag_r
      && watchdog_counter_r == 0;
  endproperty
  a_halt: assert property (p_halt) else $error("power-down entry wrong");
  property p_hold;
    halted_r |-> !op_accept ##1 ($stable(working_register_r) && !mem_we_r && !stack_push_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state changed in power-down");
endmodule
bind mis_exec mis_exec_asserts #(.PC_W(PC_W), .WDT_CNT_W(WDT_CNT_W)) u_chk (.*);
`default_nettype wire

// *** tb/tb_mis_exec.sv ***
/*
  Self-checking bench for the execution block, one task a scenario.
  Assumes default sizes but a short prescaler, so one watchdog
  timeout fits in the run; all other clears come well before it.
*/
`include "mis_exec_map.vh"
`default_nettype none
module tb_mis_exec;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRE_W = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] op_mem = 8'h00;
  logic [7:0] op_imm = 8'h00;
  logic [2:0] op_bit = 3'h0;
  logic [10:0] op_target = 11'h000;
  logic wake_req = 1'b0;
  wire op_accept, mem_we_r, carry_r, half_carry_flag_r, zero_r, twos_complement_range_flag_r;
  wire timeout_flag_r, sleep_flag_r, stack_push_r, sys_clk_en, halted_r, wdt_expire_r;
  wire [7:0] mem_wdata_r, working_register_r, watchdog_counter_r;
  wire [10:0] pc_r, stack_data_r;
  wire [2:0] stack_level_r;
  wire [3:0] fl = {twos_complement_range_flag_r, zero_r, half_carry_flag_r, carry_r};
  int n_fail = 0;
  int checked = 0;
  logic [10:0] pc_e = 11'h000;
  mis_exec #(.WDT_PRE_W(PRE_W)) uut (.*);
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs stay up so ops run back to back
  task automatic op(input logic [4:0] c, input logic [7:0] m, input logic [7:0] i);
    op_valid = 1'b1;
    op_code = c;
    op_mem = m;
    op_imm = i;
    if (!halted_r) pc_e = (c == `MIS_OP_CALL) ? op_target : pc_e + 11'h001;
    @(posedge clk);
    #1;
  endtask
  task automatic idle(input int n);
    op_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_arith;
    op(`MIS_OP_ADD_I, 8'h00, 8'h7F);
    op(`MIS_OP_ADD_I, 8'h00, 8'h01);
    chk("w", 8'h80, working_register_r);
    chk("fl", 4'hA, fl);
    op(`MIS_OP_ADD_M, 8'h80, 8'h00);
    chk("wd", 8'h00, mem_wdata_r);
    chk("fl", 4'hD, fl);
    op(`MIS_OP_ADC_W, 8'h00, 8'h00);
    chk("w", 8'h81, working_register_r);
    chk("fl", 4'h0, fl);
    op(`MIS_OP_ADC_M, 8'h7F, 8'h00);
    chk("we", 1'b1, mem_we_r);
    chk("wd", 8'h00, mem_wdata_r);
    chk("fl", 4'h7, fl);
    op(`MIS_OP_AND_I, 8'h00, 8'h0F);
    chk("w", 8'h01, working_register_r);
    chk("fl", 4'h3, fl);
    op(`MIS_OP_AND_W, 8'hFE, 8'h00);
    chk("fl", 4'h7, fl);
    op(`MIS_OP_ADD_I, 8'h00, 8'hF0);
    op(`MIS_OP_AND_M, 8'h0F, 8'h00);
    chk("wd", 8'h00, mem_wdata_r);
    chk("fl", 4'h4, fl);
    // immediate field is junk here: only the memory byte may be summed
    op(`MIS_OP_ADD_W, 8'h10, 8'hFF);
    chk("w", 8'h00, working_register_r);
    chk("fl", 4'h5, fl);
    op(`MIS_OP_NOP, 8'h33, 8'h33);
    chk("fl", 4'h5, fl);
    chk("w", 8'h00, working_register_r);
    op(`MIS_OP_ADD_W, 8'hF0, 8'h00);
    chk("w", 8'hF0, working_register_r);
    chk("fl", 4'h0, fl);
  endtask
  task automatic t_unary;
    op(`MIS_OP_INV_M, 8'hFF, 8'h00);
    chk("wd", 8'h00, mem_wdata_r);
    chk("w", 8'hF0, working_register_r);
    op(`MIS_OP_INV_W, 8'h5A, 8'h00);
    chk("w", 8'hA5, working_register_r);
    chk("we", 1'b0, mem_we_r);
    op(`MIS_OP_DEC_M, 8'h01, 8'h00);
    chk("fl", 4'h4, fl);
    op(`MIS_OP_DEC_W, 8'h00, 8'h00);
    chk("w", 8'hFF, working_register_r);
    chk("fl", 4'h0, fl);
  endtask
  // each add leaves a known half-carry and carry for the fixup
  task automatic t_bcd;
    logic [7:0] imm_t [4] = '{8'h9B, 8'h00, 8'hB8, 8'h00};
    logic [7:0] exp_t [4] = '{8'h00, 8'h00, 8'hB8, 8'h52};
    logic c_t [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      op(`MIS_OP_ADD_I, 8'h00, imm_t[i]);
      op(`MIS_OP_BCD, 8'h00, 8'h00);
      chk("bcd", exp_t[i], mem_wdata_r);
      chk("c", c_t[i], carry_r);
    end
  endtask
  task automatic t_clr;
    op(`MIS_OP_ZERO_M, 8'h5A, 8'h00);
    chk("wd", 8'h00, mem_wdata_r);
    for (int i = 0; i < 8; i++) begin
      op_bit = i[2:0];
      op(`MIS_OP_BITCLR, 8'hFF, 8'h00);
      chk("wd", 8'hFF & ~(8'h01 << i), mem_wdata_r);
    end
    chk("fl", 4'h0, fl);
  endtask
  task automatic t_call;
    logic [10:0] e;
    e = pc_e + 11'h001;
    op_target = 11'h7FF;
    op(`MIS_OP_CALL, 8'h00, 8'h00);
    chk("sd", e, stack_data_r);
    chk("push", 1'b1, stack_push_r);
    op_target = 11'h123;
    op(`MIS_OP_CALL, 8'h00, 8'h00);
    chk("sd", 11'h000, stack_data_r);
    chk("pc", pc_e, pc_r);
    chk("lvl", 3'h2, stack_level_r);
  endtask
  task automatic halt_wake;
    idle(600);
    op(`MIS_OP_HALT, 8'h00, 8'h00);
    chk("halt", 4'hA, {halted_r, sys_clk_en, sleep_flag_r, timeout_flag_r});
    chk("cnt", 8'h00, watchdog_counter_r);
    op(`MIS_OP_ADD_I, 8'h00, 8'h11);
    chk("acc", 1'b0, op_accept);
    chk("w", 8'h52, working_register_r);
    wake_req = 1'b1;
    idle(1);
    wake_req = 1'b0;
    chk("halt", 1'b0, halted_r);
    idle(600);
  endtask
  task automatic t_wdt;
    halt_wake();
    op(`MIS_OP_PRE2, 8'h00, 8'h00);
    op(`MIS_OP_PRE2, 8'h00, 8'h00);
    chk("sl", 1'b1, sleep_flag_r);
    chk("cnt0", 1'b0, watchdog_counter_r == 8'h00);
    op(`MIS_OP_PRE1, 8'h00, 8'h00);
    chk("wdt", 3'h0, {sleep_flag_r, timeout_flag_r, watchdog_counter_r == 8'h00 ? 1'b0 : 1'b1});
    chk("pc", pc_e, pc_r);
    halt_wake();
    op(`MIS_OP_KICK, 8'h00, 8'h00);
    chk("wdt", 3'h0, {sleep_flag_r, timeout_flag_r, watchdog_counter_r == 8'h00 ? 1'b0 : 1'b1});
  endtask
  // halt, then count edges until the watchdog expires and wakes the core
  task automatic t_tmo;
    int n;
    n = 0;
    op(`MIS_OP_HALT, 8'h00, 8'h00);
    op_valid = 1'b0;
    while (wdt_expire_r !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("tmo_n", 16'(1 << (PRE_W + 8)), n[15:0]);
    chk("wake", 3'h3, {halted_r, timeout_flag_r, sleep_flag_r});
    idle(1);
    chk("exp", 1'b0, wdt_expire_r);
    op(`MIS_OP_PRE1, 8'h00, 8'h00);
    chk("to", 2'h3, {timeout_flag_r, sleep_flag_r});
    op(`MIS_OP_PRE2, 8'h00, 8'h00);
    chk("to", 2'h0, {timeout_flag_r, sleep_flag_r});
    chk("cnt", 8'h00, watchdog_counter_r);
  endtask
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_arith();
    t_unary();
    t_bcd();
    t_clr();
    t_call();
    t_wdt();
    t_tmo();
    idle(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
